//--- rtl/wiper_step_pkg.sv
/*
 * constants and command types for the up/down wiper step controller.
 * assumes a 250 MHz core clock; pin timing counts derive from it.
 */
package wiper_step_pkg;

  localparam int unsigned        CLK_PERIOD_NS = 4;
  // least pin setup / hold / pulse time in ns, rounded up to whole cycles
  localparam int unsigned        SETUP_NS      = 8;
  localparam int unsigned        SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned        PULSE_NS      = 8;
  localparam int unsigned        PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned        CNT_W         = 8;

  localparam logic [5:0]         WIPER_MIN     = 6'h00;
  localparam logic [5:0]         WIPER_MAX     = 6'h3f;
  localparam logic [5:0]         WIPER_DEFAULT = 6'h1f;

  // command as presented by the user side
  typedef struct packed {
    logic       up;        // 1 increment, 0 decrement
    logic       elevated;  // use the elevated select level session
    logic       end_high;  // level of up/down left when select returns high, except a zero-step decrement ends low
    logic [5:0] steps;     // number of rising edges, 0 allowed
  } step_cmd_s;

  // select pin drive: low, elevated, or inactive high
  typedef struct packed {
    logic sel_low;
    logic elevated_select_level;
    logic up_dn;
  } pin_drive_s;

endpackage

//--- rtl/updown_wiper_step_control.sv
/*
 * host-side controller for a six-bit up/down wiper device.
 * assumes the pins leave straight from flip-flops and the device samples them
 * with its own thresholds; the elevated level is a separate drive request.
 */
// Notes on behaviour
// - host holds select inactive high before starting a command
// - compat increment ends with up/down high before select returns high
// - plain decrement ends with up/down low before select returns high
// - compat decrement of at least one step ends with up/down high before select returns high; with no steps it ends low
// - select returns high promptly after the last wanted step
`timescale 1ns/10ps

module updown_wiper_step_control
  import wiper_step_pkg::*;
#(
  parameter int unsigned SETUP_CYCLES = SETUP_CYC,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_b_i,
  // command port
  input  wire logic                      cmd_valid_i,
  input  wiper_step_pkg::step_cmd_s      cmd_i,
  input  wire logic                      device_reset_i,
  output logic                           cmd_ready_o,
  output logic                           done_o,
  output logic [5:0]                     wiper_shadow_o,
  // device pins
  output wiper_step_pkg::pin_drive_s     pins_o
);
  import wiper_step_pkg::*;

  // ****************************************
  // sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETDIR, ST_SELECT, ST_RISE, ST_FALL, ST_ENDLVL, ST_RELEASE
  } seq_state_e;

  seq_state_e       state_ff,  nxt_state;
  logic [CNT_W-1:0] cnt_ff,    nxt_cnt;
  logic [5:0]       left_ff,   nxt_left;
  step_cmd_s        cmd_ff,    nxt_cmd;
  pin_drive_s       pins_ff,   nxt_pins;
  logic [5:0]       shadow_ff, nxt_shadow;
  logic             ready_ff,  nxt_ready;
  logic             done_ff,   nxt_done;
  logic             wait_done;

  assign wait_done = (cnt_ff == '0);

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = wait_done ? cnt_ff : cnt_ff - 1'b1;
    nxt_left   = left_ff;
    nxt_cmd    = cmd_ff;
    nxt_pins   = pins_ff;
    nxt_shadow = shadow_ff;
    nxt_ready  = 1'b0;
    nxt_done   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_ready = 1'b1;
        if (cmd_valid_i && ready_ff) begin
          nxt_ready      = 1'b0;
          nxt_cmd        = cmd_i;
          nxt_left       = cmd_i.steps;
          nxt_pins.up_dn = cmd_i.up;
          nxt_cnt        = CNT_W'(SETUP_CYCLES);
          nxt_state      = ST_SETDIR;
        end
      end
      ST_SETDIR: if (wait_done) begin
        // select leaves the inactive level only after direction has settled
        if (cmd_ff.elevated) begin
          nxt_pins.elevated_select_level = 1'b1;
        end else begin
          nxt_pins.sel_low = 1'b1;
        end
        nxt_cnt   = CNT_W'(SETUP_CYCLES);
        nxt_state = ST_SELECT;
      end
      ST_SELECT: if (wait_done) begin
        // an increment session starts with up/down high, so a low phase first;
        // with no steps the level is kept, since a later rise would step the part
        nxt_pins.up_dn = (left_ff == '0) ? pins_ff.up_dn : 1'b0;
        nxt_cnt        = CNT_W'(PULSE_CYCLES);
        nxt_state      = (left_ff == '0) ? ST_ENDLVL : ST_FALL;
      end
      ST_FALL: if (wait_done) begin
        nxt_pins.up_dn = 1'b1;
        nxt_left       = left_ff - 1'b1;
        if (cmd_ff.up && shadow_ff != WIPER_MAX) begin
          nxt_shadow = shadow_ff + 1'b1;
        end else if (!cmd_ff.up && shadow_ff != WIPER_MIN) begin
          nxt_shadow = shadow_ff - 1'b1;
        end
        nxt_cnt   = CNT_W'(PULSE_CYCLES);
        nxt_state = ST_RISE;
      end
      ST_RISE: if (wait_done) begin
        nxt_cnt = CNT_W'(PULSE_CYCLES);
        if (left_ff == '0) begin
          nxt_state = ST_ENDLVL;
        end else begin
          nxt_pins.up_dn = 1'b0;
          nxt_state      = ST_FALL;
        end
      end
      ST_ENDLVL: if (wait_done) begin
        // only ever lowered here: a rise while selected is one step too many,
        // so a zero-step decrement cannot end with up/down high
        nxt_pins.up_dn = cmd_ff.end_high & pins_ff.up_dn;
        nxt_cnt        = CNT_W'(SETUP_CYCLES);
        nxt_state      = ST_RELEASE;
      end
      ST_RELEASE: if (wait_done) begin
        nxt_pins.sel_low               = 1'b0;
        nxt_pins.elevated_select_level = 1'b0;
        nxt_done                       = 1'b1;
        nxt_ready                      = 1'b1;
        nxt_state                      = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    // device power cycle: its code is back at mid-scale
    if (device_reset_i) begin
      nxt_shadow = WIPER_DEFAULT;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= '0;
      left_ff   <= '0;
      cmd_ff    <= '0;
      pins_ff   <= '0;
      shadow_ff <= WIPER_DEFAULT;
      ready_ff  <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      left_ff   <= nxt_left;
      cmd_ff    <= nxt_cmd;
      pins_ff   <= nxt_pins;
      shadow_ff <= nxt_shadow;
      ready_ff  <= nxt_ready;
      done_ff   <= nxt_done;
    end
  end

  // the device cannot be read; the shadow is the only view of its code
  assign pins_o         = pins_ff;
  assign wiper_shadow_o = shadow_ff;
  assign cmd_ready_o    = ready_ff;
  assign done_o         = done_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_sel_exclusive: assert property (
    !(pins_o.sel_low && pins_o.elevated_select_level))
    else $error("select driven low and elevated together");
  a_idle_inactive: assert property (
    (state_ff == ST_IDLE) |-> !pins_o.sel_low && !pins_o.elevated_select_level)
    else $error("select not inactive while idle");
  a_dir_stable_sel: assert property (
    $rose(pins_o.sel_low) |-> $stable(pins_o.up_dn))
    else $error("up/down moved on select edge");
  a_dir_stable_hv: assert property (
    $rose(pins_o.elevated_select_level) |-> $stable(pins_o.up_dn))
    else $error("up/down moved on elevated select edge");
  a_shadow_top: assert property (
    (shadow_ff == WIPER_MAX && cmd_ff.up && !device_reset_i) |=> shadow_ff == WIPER_MAX)
    else $error("shadow passed top");
  a_shadow_bottom: assert property (
    (shadow_ff == WIPER_MIN && !cmd_ff.up && !device_reset_i) |=> shadow_ff == WIPER_MIN)
    else $error("shadow passed bottom");
  a_step_on_rise: assert property (
    ($rose(pins_o.up_dn) && (pins_o.sel_low || pins_o.elevated_select_level)
     && cmd_ff.up && $past(shadow_ff) != WIPER_MAX && !$past(device_reset_i))
    |-> shadow_ff == $past(shadow_ff) + 6'h01)
    else $error("increment edge without step");
  a_step_dec_rise: assert property (
    ($rose(pins_o.up_dn) && (pins_o.sel_low || pins_o.elevated_select_level)
     && !cmd_ff.up && $past(shadow_ff) != WIPER_MIN && !$past(device_reset_i))
    |-> shadow_ff == $past(shadow_ff) - 6'h01)
    else $error("decrement edge without step");
  a_reset_default: assert property (
    device_reset_i |=> shadow_ff == WIPER_DEFAULT)
    else $error("shadow not reloaded");
  a_release_ready: assert property (
    done_o |-> cmd_ready_o && !pins_o.sel_low && !pins_o.elevated_select_level)
    else $error("no immediate readiness after release");

  c_normal_inc: cover property ($fell(pins_o.sel_low) && cmd_ff.up && !cmd_ff.elevated);
  c_normal_dec: cover property ($fell(pins_o.sel_low) && !cmd_ff.up);
  c_hv_session: cover property ($fell(pins_o.elevated_select_level));
  c_saturate:   cover property (shadow_ff == WIPER_MAX && $rose(pins_o.up_dn));

endmodule

//--- sim/wiper_dev_model.sv
/*
 * behavioural model of the six-bit up/down wiper device.
 * assumes the host drives the pins straight from flip-flops; no clock here.
 */
`timescale 1ns/10ps

module wiper_dev_model
  import wiper_step_pkg::*;
(
  // pins from the host
  input  wiper_step_pkg::pin_drive_s pins_i,
  input  wire logic                  power_up_i,
  // observation only: the real part offers no readback path
  output logic [5:0]                 code_o,
  output logic                       end_level_o
);
  // ****************************************
  // session state
  // ****************************************
  logic up_dir;
  logic active;
  // either select level opens a session that steps the volatile code alike
  wire sel_act = pins_i.sel_low | pins_i.elevated_select_level;

  initial begin
    code_o      = WIPER_DEFAULT;
    active      = 1'b0;
    up_dir      = 1'b0;
    end_level_o = 1'b0;
  end

  always @(posedge power_up_i) code_o = WIPER_DEFAULT;

  always @(posedge sel_act) begin
    active = 1'b1;
    up_dir = pins_i.up_dn;
  end

  // no recovery time: a new session may start at the next select edge
  always @(negedge sel_act) begin
    active      = 1'b0;
    end_level_o = pins_i.up_dn;
  end

  always @(posedge pins_i.up_dn) begin
    if (active) begin
      if (up_dir && code_o != WIPER_MAX) begin
        code_o = code_o + 6'h01;
      end else if (!up_dir && code_o != WIPER_MIN) begin
        code_o = code_o - 6'h01;
      end
    end
  end
endmodule

//--- sim/tb_top.sv
/*
 * self-checking bench for the wiper step controller with a device model.
 * assumes shortened setup and pulse counts of one cycle.
 */
`timescale 1ns/10ps

module tb_top;
  import wiper_step_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       rst_b_i    = 1'b0;
  logic       cmd_valid_i = 1'b0;
  step_cmd_s  cmd_i      = '0;
  logic       device_reset_i = 1'b0;
  logic       cmd_ready_o, done_o, end_lvl;
  logic [5:0] wiper_shadow_o, code, exp_code;
  pin_drive_s pins_o;
  int         error_cnt  = 0;
  int         checks_done = 0;

  always #2 core_clk_i = ~core_clk_i;

  updown_wiper_step_control #(.SETUP_CYCLES(1), .PULSE_CYCLES(1)) updown_wiper_step_control_inst (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .device_reset_i(device_reset_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .wiper_shadow_o(wiper_shadow_o), .pins_o(pins_o));
  wiper_dev_model wiper_dev_model_inst (
    .pins_i(pins_o), .power_up_i(device_reset_i), .code_o(code), .end_level_o(end_lvl));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run_cmd(input logic up, input logic elev, input logic endh, input logic [5:0] n);
    int i;
    i = 0;
    while (cmd_ready_o !== 1'b1 && i < 100) begin @(negedge core_clk_i); i++; end
    chk("ready idle", 6'h01, {5'h00, cmd_ready_o});
    cmd_i = {up, elev, endh, n};
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    chk("ready busy", 6'h00, {5'h00, cmd_ready_o});
    i = 0;
    while (done_o !== 1'b1 && i < 2000) begin @(negedge core_clk_i); i++; end
    chk("done seen", 6'h01, {5'h00, done_o});
    for (i = 0; i < n; i++) begin
      if (up && exp_code != WIPER_MAX) exp_code = exp_code + 6'h01;
      if (!up && exp_code != WIPER_MIN) exp_code = exp_code - 6'h01;
    end
    chk("select idle", 6'h00, {4'h0, pins_o.sel_low, pins_o.elevated_select_level});
    chk("shadow", exp_code, wiper_shadow_o);
    chk("device code", exp_code, code);
    chk("end level", {5'h00, endh}, {5'h00, end_lvl});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_default();
    exp_code = WIPER_DEFAULT;
    chk("reset shadow", WIPER_DEFAULT, wiper_shadow_o);
    chk("power-up code", WIPER_DEFAULT, code);
    $display("test default done");
  endtask

  task automatic t_variants();
    int k;
    for (k = 0; k < 8; k++) run_cmd(k[0], k[1], k[2], 6'h03);
    run_cmd(1'b1, 1'b0, 1'b0, 6'h00);
    run_cmd(1'b1, 1'b1, 1'b1, 6'h00);
    $display("test variants done");
  endtask

  task automatic t_saturate();
    run_cmd(1'b1, 1'b0, 1'b1, 6'h3f);
    run_cmd(1'b1, 1'b1, 1'b0, 6'h02);
    run_cmd(1'b0, 1'b0, 1'b1, 6'h3f);
    run_cmd(1'b0, 1'b0, 1'b0, 6'h02);
    run_cmd(1'b0, 1'b1, 1'b0, 6'h02);
    $display("test saturate done");
  endtask

  task automatic t_reload();
    run_cmd(1'b1, 1'b0, 1'b1, 6'h05);
    device_reset_i = 1'b1;
    @(negedge core_clk_i);
    device_reset_i = 1'b0;
    exp_code = WIPER_DEFAULT;
    chk("reload shadow", exp_code, wiper_shadow_o);
    chk("reload code", exp_code, code);
    run_cmd(1'b0, 1'b0, 1'b0, 6'h04);
    $display("test reload done");
  endtask

  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    @(negedge core_clk_i);
    t_default();
    t_variants();
    t_saturate();
    t_reload();
    final_report();
  end

  // generous bound: about 20 commands of at most about 270 cycles each
  initial begin
    #80000;
    error_cnt++;
    final_report();
  end
endmodule
